// ==== rtl/wssr_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// - signature byte alternates two identity values per read
// - upper sixteen signature bits are driver scratch
// - reserved bits read zero, ignore writes
// - pattern frame flags set when detector enabled
// - magic flag sets when magic detector enabled
// - flags clear on write one, zero ignored
// - bit one enables pattern frame detector
// - bit zero enables magic packet detector
// - D3hot to D0 clears both enables
// - no pm capability forces enables to zero
// - boot load sets magic enable from default
// - wakeup resets to top bit; 31:30 writable
// - capability pointer follows pm capability bit
module wssr_regs #(
    parameter logic [7:0] ID_ODD_READ = wssr_pkg::ID_ODD_DEFAULT,
    parameter logic [7:0] ID_EVEN_READ = wssr_pkg::ID_EVEN_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration access
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_valid,
    // detector events and power state
    input wire logic [3:0] pattern_frame_rx,
    input wire logic magic_packet_rx,
    input wire logic d3hot_to_d0,
    // detector enables
    output logic pattern_detect_enable,
    output logic magic_detect_enable
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction

    logic sel_signature;
    logic sel_wk;
    logic sel_cap;
    logic wr_signature;
    logic wr_wk;
    logic [15:0] driver_scratch_field;
    logic [15:0] next_scratch;
    logic pm_capability_present;
    logic next_pm_cap;
    logic wake_default_latch;
    logic next_wake_def;
    logic next_pat_en;
    logic next_mag_en;
    logic boot_pending;
    logic next_boot_pending;
    logic id_phase;
    logic next_id_phase;
    logic [31:0] next_rdata;
    logic next_rd_valid;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [4:0] flags;
    logic [7:0] identity_byte;

    assign sel_signature = hit(cfg_addr, wssr_pkg::OFF_SIGNATURE);
    assign sel_wk = hit(cfg_addr, wssr_pkg::OFF_WAKEUP);
    assign sel_cap = hit(cfg_addr, wssr_pkg::OFF_CAP_PTR);
    assign wr_signature = cfg_wr && sel_signature;
    assign wr_wk = cfg_wr && sel_wk;
    assign identity_byte = id_phase ? ID_EVEN_READ : ID_ODD_READ;

    // control and configuration bits
    always_comb begin
        next_scratch = driver_scratch_field;
        next_pm_cap = pm_capability_present;
        next_wake_def = wake_default_latch;
        next_pat_en = pattern_detect_enable;
        next_mag_en = magic_detect_enable;
        next_boot_pending = boot_pending;
        if (wr_signature && cfg_be[2]) begin
            next_scratch[7:0] = cfg_wdata[23:16];
        end
        if (wr_signature && cfg_be[3]) begin
            next_scratch[15:8] = cfg_wdata[31:24];
        end
        if (wr_wk && cfg_be[3]) begin
            next_pm_cap = cfg_wdata[wssr_pkg::PMCAP_BIT];
            next_wake_def = cfg_wdata[wssr_pkg::WAKEDEF_BIT];
        end
        if (wr_wk && cfg_be[0]) begin
            next_pat_en = cfg_wdata[wssr_pkg::PAT_EN_BIT];
            next_mag_en = cfg_wdata[wssr_pkg::MAG_EN_BIT];
        end
        // first load of the strap byte after reset seeds magic enable
        if (boot_pending && wr_wk && cfg_be[3]) begin
            next_mag_en = cfg_wdata[wssr_pkg::PMCAP_BIT] &
                          cfg_wdata[wssr_pkg::WAKEDEF_BIT];
            next_boot_pending = 1'b0;
        end
        if (d3hot_to_d0) begin
            next_pat_en = 1'b0;
            next_mag_en = 1'b0;
        end
        if (!next_pm_cap) begin
            next_pat_en = 1'b0;
            next_mag_en = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driver_scratch_field <= wssr_pkg::SCRATCH_RESET;
            pm_capability_present <= wssr_pkg::WAKEUP_RESET[wssr_pkg::PMCAP_BIT];
            wake_default_latch <= wssr_pkg::WAKEUP_RESET[wssr_pkg::WAKEDEF_BIT];
            pattern_detect_enable <= wssr_pkg::WAKEUP_RESET[wssr_pkg::PAT_EN_BIT];
            magic_detect_enable <= wssr_pkg::WAKEUP_RESET[wssr_pkg::MAG_EN_BIT];
            boot_pending <= 1'b1;
        end else begin
            driver_scratch_field <= next_scratch;
            pm_capability_present <= next_pm_cap;
            wake_default_latch <= next_wake_def;
            pattern_detect_enable <= next_pat_en;
            magic_detect_enable <= next_mag_en;
            boot_pending <= next_boot_pending;
        end
    end

    // sticky wake flags, bit 0 magic, bits 4:1 patterns 0..3
    always_comb begin
        flag_set = {pattern_frame_rx & {4{pattern_detect_enable}},
                    magic_packet_rx & magic_detect_enable};
        flag_clr = '0;
        if (wr_wk && cfg_be[2]) begin
            flag_clr = cfg_wdata[wssr_pkg::FLAG_LSB +: wssr_pkg::FLAG_W];
        end
    end

    wssr_sticky #(
        .W(wssr_pkg::FLAG_W)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(flag_set),
        .clr(flag_clr),
        .q(flags)
    );

    // read path, data held until the next read
    always_comb begin
        next_rdata = cfg_rdata;
        next_rd_valid = cfg_rd;
        next_id_phase = id_phase;
        if (cfg_rd) begin
            next_rdata = 32'h0000_0000;
            if (sel_signature) begin
                next_rdata[wssr_pkg::SCRATCH_LSB +: wssr_pkg::SCRATCH_W] = driver_scratch_field;
                next_rdata[wssr_pkg::ID_LSB +: wssr_pkg::ID_W] = identity_byte;
                next_id_phase = ~id_phase;
            end else if (sel_wk) begin
                next_rdata[wssr_pkg::PMCAP_BIT] = pm_capability_present;
                next_rdata[wssr_pkg::WAKEDEF_BIT] = wake_default_latch;
                next_rdata[wssr_pkg::FLAG_LSB +: wssr_pkg::FLAG_W] = flags;
                next_rdata[wssr_pkg::PAT_EN_BIT] = pattern_detect_enable;
                next_rdata[wssr_pkg::MAG_EN_BIT] = magic_detect_enable;
            end else if (sel_cap) begin
                next_rdata[7:0] = pm_capability_present ? wssr_pkg::CAP_PTR_PM
                                                        : wssr_pkg::CAP_PTR_NONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rd_valid <= 1'b0;
            id_phase <= 1'b0;
        end else begin
            cfg_rdata <= next_rdata;
            cfg_rd_valid <= next_rd_valid;
            id_phase <= next_id_phase;
        end
    end

    // helper state watched only by the checks below
    logic rd_was_signature;
    logic next_rd_was_signature;
    logic rd_was_wk;
    logic next_rd_was_wk;
    logic have_prev_id;
    logic next_have_prev_id;
    logic [7:0] last_id;
    logic [7:0] next_last_id;

    always_comb begin
        next_rd_was_signature = cfg_rd && sel_signature;
        next_rd_was_wk = cfg_rd && sel_wk;
        next_have_prev_id = have_prev_id;
        next_last_id = last_id;
        if (cfg_rd_valid && rd_was_signature) begin
            next_have_prev_id = 1'b1;
            next_last_id = cfg_rdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_was_signature <= 1'b0;
            rd_was_wk <= 1'b0;
            have_prev_id <= 1'b0;
            last_id <= 8'h00;
        end else begin
            rd_was_signature <= next_rd_was_signature;
            rd_was_wk <= next_rd_was_wk;
            have_prev_id <= next_have_prev_id;
            last_id <= next_last_id;
        end
    end

    sequence s_scratch_write;
        wr_signature && cfg_be[3:2] == 2'b11 && !cfg_rd;
    endsequence

    sequence s_signature_read;
        cfg_rd && sel_signature && !cfg_wr;
    endsequence

    property p_id_alternate;
        @(posedge clk) disable iff (!rst_n)
        (cfg_rd_valid && rd_was_signature) |->
            (have_prev_id ? (cfg_rdata[7:0] != last_id) : (cfg_rdata[7:0] == ID_ODD_READ));
    endproperty
    a_id_alternate: assert property (p_id_alternate) else $error("id byte stuck");

    property p_scratch_keep;
        @(posedge clk) disable iff (!rst_n)
        s_scratch_write ##1 !cfg_wr ##1 s_signature_read |=>
            cfg_rdata[31:16] == $past(cfg_wdata[31:16], 3);
    endproperty
    a_scratch_keep: assert property (p_scratch_keep) else $error("scratch field changed");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        cfg_rd_valid |->
            (!rd_was_signature || cfg_rdata[15:8] == 8'h00) &&
            (!rd_was_wk || (cfg_rdata[29:21] == 9'h000 && cfg_rdata[15:2] == 14'h0000));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_en_write;
        @(posedge clk) disable iff (!rst_n)
        (wr_wk && cfg_be[0] && !cfg_be[3] && pm_capability_present && !d3hot_to_d0) |=>
            pattern_detect_enable == $past(cfg_wdata[wssr_pkg::PAT_EN_BIT]) &&
            magic_detect_enable == $past(cfg_wdata[wssr_pkg::MAG_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not written");

    property p_pattern_set;
        @(posedge clk) disable iff (!rst_n)
        (pattern_frame_rx != 4'h0 && pattern_detect_enable) |=>
            (flags[4:1] & $past(pattern_frame_rx)) == $past(pattern_frame_rx);
    endproperty
    a_pattern_set: assert property (p_pattern_set) else $error("pattern flag not set");

    property p_magic_set;
        @(posedge clk) disable iff (!rst_n)
        (magic_packet_rx && magic_detect_enable) |=> flags[0] ##1 (flags[0] || $past(flag_clr[0]));
    endproperty
    a_magic_set: assert property (p_magic_set) else $error("magic flag not set");

    property p_w1c;
        @(posedge clk) disable iff (!rst_n)
        (flag_clr[0] && !flag_set[0]) |=> !flags[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("magic flag not cleared");

    property p_flag_hold;
        @(posedge clk) disable iff (!rst_n)
        (flags != 5'h00 && !(wr_wk && cfg_be[2])) |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

    property p_d3_clear;
        @(posedge clk) disable iff (!rst_n)
        d3hot_to_d0 |=> !pattern_detect_enable && !magic_detect_enable;
    endproperty
    a_d3_clear: assert property (p_d3_clear) else $error("enables kept after D3hot exit");

    property p_no_pm_cap;
        @(posedge clk) disable iff (!rst_n)
        !pm_capability_present |-> !pattern_detect_enable && !magic_detect_enable;
    endproperty
    a_no_pm_cap: assert property (p_no_pm_cap) else $error("enable without pm cap");

    property p_boot_seed;
        @(posedge clk) disable iff (!rst_n)
        (boot_pending && wr_wk && cfg_be[3] && !d3hot_to_d0) |=>
            magic_detect_enable == $past(cfg_wdata[wssr_pkg::PMCAP_BIT] &
                                         cfg_wdata[wssr_pkg::WAKEDEF_BIT]) && !boot_pending;
    endproperty
    a_boot_seed: assert property (p_boot_seed) else $error("magic enable not seeded");

    property p_cap_ptr;
        @(posedge clk) disable iff (!rst_n)
        (cfg_rd && sel_cap) |=> cfg_rd_valid && cfg_rdata[31:8] == 24'h000000 &&
            cfg_rdata[7:0] == ($past(pm_capability_present) ? wssr_pkg::CAP_PTR_PM :
                               wssr_pkg::CAP_PTR_NONE);
    endproperty
    a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer wrong");

endmodule

// ==== inc/wssr_pkg.sv ====
package wssr_pkg;

    // configuration space byte offsets
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_SIGNATURE = 8'h40;
    localparam logic [7:0] OFF_WAKEUP = 8'h48;

    // signature register layout
    localparam int SCRATCH_LSB = 16;
    localparam int SCRATCH_W = 16;
    localparam int ID_LSB = 0;
    localparam int ID_W = 8;
    localparam logic [15:0] SCRATCH_RESET = 16'h0000;

    // arbitrary neutral identity values
    localparam logic [7:0] ID_ODD_DEFAULT = 8'hA5;
    localparam logic [7:0] ID_EVEN_DEFAULT = 8'h3C;

    // wakeup control and status layout
    localparam int PMCAP_BIT = 31;
    localparam int WAKEDEF_BIT = 30;
    localparam int FLAG_LSB = 16;
    localparam int FLAG_W = 5;
    localparam int MAGIC_FLAG_BIT = 16;
    localparam int PAT_FLAG_LSB = 17;
    localparam int PAT_EN_BIT = 1;
    localparam int MAG_EN_BIT = 0;
    localparam logic [31:0] WAKEUP_RESET = 32'h8000_0000;

    // capability pointer values
    localparam logic [7:0] CAP_PTR_PM = 8'hDC;
    localparam logic [7:0] CAP_PTR_NONE = 8'h00;

endpackage

// ==== rtl/wssr_sticky.sv ====
`timescale 1ns/1ps
module wssr_sticky #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // set and clear vectors, set wins
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flag state
    output logic [W-1:0] q
);

    logic [W-1:0] next_q;

    always_comb begin
        next_q = (q & ~clr) | set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule

// ==== tb/wssr_host.sv ====
`timescale 1ns/1ps
module wssr_host (
    // clock
    input wire logic clk,
    // request side
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // answer side
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid
);
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // released strobes drop low, other lines carry the inverse of their last value
    task automatic release_bus();
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_addr <= ~cfg_addr;
        cfg_be <= ~cfg_be;
        cfg_wdata <= ~cfg_wdata;
    endtask

    task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be,
                             input logic [31:0] data);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= addr;
        cfg_be <= be;
        cfg_wdata <= data;
        @(posedge clk);
        release_bus();
    endtask

    task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data,
                            output logic ok);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= addr;
        @(posedge clk);
        release_bus();
        #1;
        ok = cfg_rd_valid;
        data = cfg_rdata;
    endtask
endmodule

// ==== tb/wssr_regs_test.sv ====
`timescale 1ns/1ps
module wssr_regs_test;
    logic clk;
    logic rst_n;
    logic cfg_rd;
    logic cfg_wr;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic cfg_rd_valid;
    logic [3:0] pattern_frame_rx;
    logic magic_packet_rx;
    logic d3hot_to_d0;
    logic pattern_detect_enable;
    logic magic_detect_enable;
    int errors;
    int checks;
    int id_reads;
    localparam logic [7:0] WK = wssr_pkg::OFF_WAKEUP;
    localparam logic [7:0] CP = wssr_pkg::OFF_CAP_PTR;

    wssr_regs dut_u (.clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid), .pattern_frame_rx(pattern_frame_rx),
        .magic_packet_rx(magic_packet_rx), .d3hot_to_d0(d3hot_to_d0),
        .pattern_detect_enable(pattern_detect_enable),
        .magic_detect_enable(magic_detect_enable));

    wssr_host host_u (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        host_u.cfg_read(addr, d, ok);
        check({31'h0, ok}, 32'h0000_0001);
        check(d, exp);
    endtask

    task automatic rd_id(input logic [15:0] scratch);
        rd(wssr_pkg::OFF_SIGNATURE, {scratch, 8'h00,
           id_reads[0] ? wssr_pkg::ID_EVEN_DEFAULT : wssr_pkg::ID_ODD_DEFAULT});
        id_reads++;
    endtask

    task automatic en(input logic [1:0] exp);
        #1;
        check({30'h0, pattern_detect_enable, magic_detect_enable}, {30'h0, exp});
    endtask

    task automatic evt(input logic [3:0] pat, input logic mag, input logic pwr);
        @(posedge clk);
        pattern_frame_rx <= pat;
        magic_packet_rx <= mag;
        d3hot_to_d0 <= pwr;
        @(posedge clk);
        pattern_frame_rx <= 4'h0;
        magic_packet_rx <= 1'b0;
        d3hot_to_d0 <= 1'b0;
    endtask

    task automatic summarize();
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #(100 * 2000);
        errors++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        pattern_frame_rx = 4'h0;
        magic_packet_rx = 1'b0;
        d3hot_to_d0 = 1'b0;
        errors = 0;
        checks = 0;
        id_reads = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        en(2'b00);
        rd(WK, 32'h8000_0000);
        rd(CP, {24'h0, wssr_pkg::CAP_PTR_PM});
        rd_id(16'h0000);
        rd(8'h44, 32'h0000_0000);
        rd_id(16'h0000);
        host_u.cfg_write(wssr_pkg::OFF_SIGNATURE, 4'hF, 32'hFFFF_FFFF);
        rd_id(16'hFFFF);
        host_u.cfg_write(wssr_pkg::OFF_SIGNATURE, 4'h4, 32'h1234_5678);
        rd_id(16'hFF34);
        host_u.cfg_write(WK, 4'hF, 32'hFFE0_FFFE);
        en(2'b11);
        rd(WK, 32'hC000_0003);
        evt(4'hF, 1'b1, 1'b0);
        rd(WK, 32'hC01F_0003);
        host_u.cfg_write(WK, 4'h4, 32'h0005_0000);
        rd(WK, 32'hC01A_0003);
        host_u.cfg_write(WK, 4'h1, 32'h0000_0000);
        rd(WK, 32'hC01A_0000);
        host_u.cfg_write(WK, 4'h4, 32'h001F_0000);
        evt(4'hF, 1'b1, 1'b0);
        rd(WK, 32'hC000_0000);
        host_u.cfg_write(WK, 4'h1, 32'h0000_0002);
        evt(4'h5, 1'b1, 1'b0);
        rd(WK, 32'hC00A_0002);
        host_u.cfg_write(WK, 4'h1, 32'h0000_0001);
        evt(4'hA, 1'b1, 1'b0);
        rd(WK, 32'hC00B_0001);
        host_u.cfg_write(WK, 4'h1, 32'h0000_0003);
        en(2'b11);
        evt(4'h0, 1'b0, 1'b1);
        en(2'b00);
        rd(WK, 32'hC00B_0000);
        host_u.cfg_write(WK, 4'h8, 32'h0000_0000);
        host_u.cfg_write(WK, 4'h1, 32'h0000_0003);
        en(2'b00);
        rd(WK, 32'h000B_0000);
        rd(CP, {24'h0, wssr_pkg::CAP_PTR_NONE});
        summarize();
    end
endmodule
